//--- shared/dbtc_pkg.sv
// package for the dma burst and threshold control block
// Contract
// - registers decode in upper 2K of window
// - offsets 0x800, 0x808 and 0x840
// - eeprom loads the three registers when present
// - isoch tx read burst is 16*(n+1)
// - isoch tx requests when enough free space
// - isoch rx write burst is 16*(n+1)
// - isoch rx requests when enough data waits
// - link notified when packet quadlets reach level
// - link notified when whole packet present
// - async tx read burst is 16*(n+1)
// - async tx requests when enough free space
// - async rx write burst is 16*(n+1)
// - async rx requests when enough data waits
// - physical write minimum burst is rx threshold
// - bursts shortened by packet, buffer, fifo, cache
package dbtc_pkg;
  // ****************************************
  // address map
  // ****************************************
  localparam int          DBTC_AW         = 12;
  localparam int          DBTC_DW         = 32;
  localparam logic [11:0] DBTC_OFS_ISO    = 12'h800;
  localparam logic [11:0] DBTC_OFS_ASYNC  = 12'h808;
  localparam logic [11:0] DBTC_OFS_LINK   = 12'h840;
  localparam int          DBTC_HALF_BIT   = 11;
  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [31:0] DBTC_RST_ISO    = 32'h0000_7373;
  localparam logic [31:0] DBTC_RST_ASYNC  = 32'h0010_7373;
  localparam logic [31:0] DBTC_RST_LINK   = 32'h0000_0020;
  localparam logic [31:0] DBTC_MSK_ISO    = 32'h0000_ffff;
  localparam logic [31:0] DBTC_MSK_ASYNC  = 32'h00ff_ffff;
  localparam logic [31:0] DBTC_MSK_LINK   = 32'h0000_003f;
  // ****************************************
  // field positions
  // ****************************************
  localparam int          DBTC_F_TX_BURST = 12;
  localparam int          DBTC_F_TX_THR   = 8;
  localparam int          DBTC_F_RX_BURST = 4;
  localparam int          DBTC_F_RX_THR   = 0;
  localparam int          DBTC_F_NOTIFY   = 16;
  localparam int          DBTC_F_POSTED   = 3;
  localparam int          DBTC_F_CYCLE    = 0;
  localparam int          DBTC_NW         = 4;
  // ****************************************
  // eeprom targets and sizes
  // ****************************************
  localparam logic [1:0]  DBTC_EE_ISO     = 2'h0;
  localparam logic [1:0]  DBTC_EE_ASYNC   = 2'h1;
  localparam logic [1:0]  DBTC_EE_LINK    = 2'h2;
  localparam int          DBTC_QW         = 12;
  localparam int          DBTC_STEP_SH    = 4;
  localparam int          DBTC_NUNITS     = 4;
  typedef enum logic [1:0] {
    DBTC_U_ITX, DBTC_U_IRX, DBTC_U_ATX, DBTC_U_ARX
  } dbtc_unit_t;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic                en;
    logic [DBTC_QW-1:0]  level;
    logic [DBTC_QW-1:0]  remain;
  } dbtc_unit_in_t;
  typedef struct packed {
    logic                req;
    logic [DBTC_QW-1:0]  burst;
  } dbtc_unit_out_t;
  // 16*(n+1) quadlets
  function automatic logic [DBTC_QW-1:0] dbtc_quads(input logic [3:0] n);
    logic [DBTC_QW-1:0] v;
    v = {8'h00, n} + 12'h001;
    return DBTC_QW'(v << DBTC_STEP_SH);
  endfunction
endpackage

//--- rtl/dbtc_unit.sv
// request and burst sizing for one dma unit
`timescale 1ns/10ps
module dbtc_unit
(
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst_n,
  input  wire logic [3:0]                    i_burst_n,
  input  wire logic [3:0]                    i_thr_n,
  input  wire logic [dbtc_pkg::DBTC_QW-1:0]  i_cache_quads,
  input  wire dbtc_pkg::dbtc_unit_in_t       i_ctl,
  output dbtc_pkg::dbtc_unit_out_t           o_res
);
  import dbtc_pkg::*;
  // ****************************************
  // sizing
  // ****************************************
  logic [DBTC_QW-1:0] thr_q;
  logic [DBTC_QW-1:0] max_q;
  logic [DBTC_QW-1:0] need_q;
  logic [DBTC_QW-1:0] lim_q;
  dbtc_unit_out_t     res_r;
  dbtc_unit_out_t     res_nxt;
  always_comb
  begin
    thr_q   = dbtc_quads(i_thr_n);
    max_q   = dbtc_quads(i_burst_n);
    // short remainder lowers the threshold
    need_q  = (i_ctl.remain < thr_q) ? i_ctl.remain : thr_q;
    lim_q   = max_q;
    if (i_ctl.level < lim_q)
      lim_q = i_ctl.level;
    if (i_ctl.remain < lim_q)
      lim_q = i_ctl.remain;
    if ((i_cache_quads != '0) && (i_cache_quads < lim_q))
      lim_q = i_cache_quads;
    res_nxt.req   = i_ctl.en && (i_ctl.remain != '0) && (i_ctl.level >= need_q);
    // request held while condition holds, one burst each grant
    res_nxt.burst = res_nxt.req ? lim_q : '0;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      res_r <= '0;
    else
      res_r <= res_nxt;
  end
  assign o_res = res_r;
  // ****************************************
  // checks
  // ****************************************
  property p_burst_cap;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_res.req |-> o_res.burst <= dbtc_quads($past(i_burst_n));
  endproperty
  a_burst_cap: assert property (p_burst_cap) else $error("burst above limit");
  property p_req_level;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ctl.en && i_ctl.level >= dbtc_quads(i_thr_n) && i_ctl.remain >= dbtc_quads(i_thr_n))
      |=> o_res.req;
  endproperty
  a_req_level: assert property (p_req_level) else $error("request missed");
  property p_no_req_low;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ctl.level < i_ctl.remain && i_ctl.level < dbtc_quads(i_thr_n)) |=> !o_res.req;
  endproperty
  a_no_req_low: assert property (p_no_req_low) else $error("early request");
  property p_short_pkt;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ctl.en && i_ctl.remain != '0 && i_ctl.level >= i_ctl.remain) |=> o_res.req;
  endproperty
  a_short_pkt: assert property (p_short_pkt) else $error("short packet stuck");
  property p_burst_remain;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_res.req |-> (o_res.burst <= $past(i_ctl.remain)) && (o_res.burst <= $past(i_ctl.level));
  endproperty
  a_burst_remain: assert property (p_burst_remain) else $error("burst not shortened");
endmodule // dbtc_unit

//--- rtl/dbtc_top.sv
// vendor register file and dma request control
`timescale 1ns/10ps
module dbtc_top
(
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst_n,
  input  wire logic [dbtc_pkg::DBTC_AW-1:0]  i_mem_addr,
  input  wire logic                          i_mem_wr,
  input  wire logic                          i_mem_rd,
  input  wire logic [3:0]                    i_mem_be,
  input  wire logic [dbtc_pkg::DBTC_DW-1:0]  i_mem_wdata,
  output logic                               o_mem_hit,
  output logic [dbtc_pkg::DBTC_DW-1:0]       o_mem_rdata,
  output logic                               o_mem_rvalid,
  input  wire logic                          i_ee_wr,
  input  wire logic [1:0]                    i_ee_sel,
  input  wire logic [dbtc_pkg::DBTC_DW-1:0]  i_ee_word,
  input  wire logic [dbtc_pkg::DBTC_QW-1:0]  i_cache_quads,
  input  wire dbtc_pkg::dbtc_unit_in_t       i_isoch_tx_unit,
  input  wire dbtc_pkg::dbtc_unit_in_t       i_isoch_rx_unit,
  input  wire dbtc_pkg::dbtc_unit_in_t       i_async_tx_unit,
  input  wire dbtc_pkg::dbtc_unit_in_t       i_async_rx_unit,
  output dbtc_pkg::dbtc_unit_out_t           o_isoch_tx_unit,
  output dbtc_pkg::dbtc_unit_out_t           o_isoch_rx_unit,
  output dbtc_pkg::dbtc_unit_out_t           o_async_tx_unit,
  output dbtc_pkg::dbtc_unit_out_t           o_async_rx_unit,
  input  wire logic [dbtc_pkg::DBTC_QW-1:0]  i_at_pkt_quads,
  input  wire logic                          i_at_pkt_whole,
  output logic                               o_async_tx_link_notify,
  output logic [2:0]                         o_link_posted_writes,
  output logic [2:0]                         o_link_cycle_sel
);
  import dbtc_pkg::*;
  // ****************************************
  // register file
  // ****************************************
  logic [31:0] iso_dma_bus_control_r;
  logic [31:0] iso_dma_bus_control_nxt;
  logic [31:0] async_dma_bus_control_r;
  logic [31:0] async_dma_bus_control_nxt;
  logic [31:0] link_tuning_options_r;
  logic [31:0] link_tuning_options_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] be_mask;
  logic        sel_iso;
  logic        sel_async;
  logic        sel_link;

  // upper half of the 4K window only
  assign o_mem_hit = i_mem_addr[DBTC_HALF_BIT];

  always_comb
  begin
    sel_iso   = o_mem_hit && (i_mem_addr == DBTC_OFS_ISO);
    sel_async = o_mem_hit && (i_mem_addr == DBTC_OFS_ASYNC);
    sel_link  = o_mem_hit && (i_mem_addr == DBTC_OFS_LINK);
    for (int b = 0; b < DBTC_NW; b++)
      be_mask[b*8 +: 8] = {8{i_mem_be[b]}};
    iso_dma_bus_control_nxt   = iso_dma_bus_control_r;
    async_dma_bus_control_nxt = async_dma_bus_control_r;
    link_tuning_options_nxt   = link_tuning_options_r;
    if (i_ee_wr)
    begin
      // eeprom image overrides field defaults
      unique case (i_ee_sel)
        DBTC_EE_ISO:   iso_dma_bus_control_nxt   = i_ee_word & DBTC_MSK_ISO;
        DBTC_EE_ASYNC: async_dma_bus_control_nxt = i_ee_word & DBTC_MSK_ASYNC;
        DBTC_EE_LINK:  link_tuning_options_nxt   = i_ee_word & DBTC_MSK_LINK;
        default:       iso_dma_bus_control_nxt   = iso_dma_bus_control_r;
      endcase
    end
    else if (i_mem_wr)
    begin
      // byte lanes, undefined bits stay zero
      if (sel_iso)
        iso_dma_bus_control_nxt = ((iso_dma_bus_control_r & ~be_mask)
                                  | (i_mem_wdata & be_mask)) & DBTC_MSK_ISO;
      if (sel_async)
        async_dma_bus_control_nxt = ((async_dma_bus_control_r & ~be_mask)
                                    | (i_mem_wdata & be_mask)) & DBTC_MSK_ASYNC;
      if (sel_link)
        link_tuning_options_nxt = ((link_tuning_options_r & ~be_mask)
                                  | (i_mem_wdata & be_mask)) & DBTC_MSK_LINK;
    end
    // unmapped upper-half offsets read zero
    rvalid_nxt = i_mem_rd && o_mem_hit;
    rdata_nxt  = '0;
    if (i_mem_rd && sel_iso)
      rdata_nxt = iso_dma_bus_control_r;
    if (i_mem_rd && sel_async)
      rdata_nxt = async_dma_bus_control_r;
    if (i_mem_rd && sel_link)
      rdata_nxt = link_tuning_options_r;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      iso_dma_bus_control_r   <= DBTC_RST_ISO;
      async_dma_bus_control_r <= DBTC_RST_ASYNC;
      link_tuning_options_r   <= DBTC_RST_LINK;
      rdata_r                 <= '0;
      rvalid_r                <= 1'b0;
    end
    else
    begin
      iso_dma_bus_control_r   <= iso_dma_bus_control_nxt;
      async_dma_bus_control_r <= async_dma_bus_control_nxt;
      link_tuning_options_r   <= link_tuning_options_nxt;
      rdata_r                 <= rdata_nxt;
      rvalid_r                <= rvalid_nxt;
    end
  end

  assign o_mem_rdata          = rdata_r;
  assign o_mem_rvalid         = rvalid_r;
  assign o_link_posted_writes = link_tuning_options_r[DBTC_F_POSTED +: 3];
  assign o_link_cycle_sel     = link_tuning_options_r[DBTC_F_CYCLE +: 3];

  // ****************************************
  // dma units
  // ****************************************
  logic [3:0]     burst_n [DBTC_NUNITS];
  logic [3:0]     thr_n   [DBTC_NUNITS];
  dbtc_unit_in_t  u_in    [DBTC_NUNITS];
  dbtc_unit_out_t u_out   [DBTC_NUNITS];

  always_comb
  begin
    burst_n[DBTC_U_ITX] = iso_dma_bus_control_r[DBTC_F_TX_BURST +: 4];
    thr_n[DBTC_U_ITX]   = iso_dma_bus_control_r[DBTC_F_TX_THR +: 4];
    burst_n[DBTC_U_IRX] = iso_dma_bus_control_r[DBTC_F_RX_BURST +: 4];
    thr_n[DBTC_U_IRX]   = iso_dma_bus_control_r[DBTC_F_RX_THR +: 4];
    burst_n[DBTC_U_ATX] = async_dma_bus_control_r[DBTC_F_TX_BURST +: 4];
    thr_n[DBTC_U_ATX]   = async_dma_bus_control_r[DBTC_F_TX_THR +: 4];
    burst_n[DBTC_U_ARX] = async_dma_bus_control_r[DBTC_F_RX_BURST +: 4];
    // also the physical write minimum burst
    thr_n[DBTC_U_ARX]   = async_dma_bus_control_r[DBTC_F_RX_THR +: 4];
    u_in[DBTC_U_ITX]    = i_isoch_tx_unit;
    u_in[DBTC_U_IRX]    = i_isoch_rx_unit;
    u_in[DBTC_U_ATX]    = i_async_tx_unit;
    u_in[DBTC_U_ARX]    = i_async_rx_unit;
  end

  for (genvar g = 0; g < DBTC_NUNITS; g++)
  begin : g_unit
    dbtc_unit u_unit
    (
      .i_clk_sys     (i_clk_sys),
      .i_rst_n       (i_rst_n),
      .i_burst_n     (burst_n[g]),
      .i_thr_n       (thr_n[g]),
      .i_cache_quads (i_cache_quads),
      .i_ctl         (u_in[g]),
      .o_res         (u_out[g])
    );
  end

  assign o_isoch_tx_unit = u_out[DBTC_U_ITX];
  assign o_isoch_rx_unit = u_out[DBTC_U_IRX];
  assign o_async_tx_unit = u_out[DBTC_U_ATX];
  assign o_async_rx_unit = u_out[DBTC_U_ARX];

  // ****************************************
  // async transmit link notify
  // ****************************************
  logic [7:0] notify_level;
  logic       notify_r;
  logic       notify_nxt;

  always_comb
  begin
    notify_level = async_dma_bus_control_r[DBTC_F_NOTIFY +: 8];
    notify_nxt   = (i_at_pkt_quads >= {4'h0, notify_level})
                   || i_at_pkt_whole;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      notify_r <= 1'b0;
    else
      notify_r <= notify_nxt;
  end

  assign o_async_tx_link_notify = notify_r;

  // ****************************************
  // checks
  // ****************************************
  sequence s_iso_write;
    i_mem_wr && !i_ee_wr && (i_mem_addr == DBTC_OFS_ISO) && (i_mem_be == 4'hf);
  endsequence
  sequence s_iso_read;
    ##1 i_mem_rd && (i_mem_addr == DBTC_OFS_ISO) ##1 o_mem_rvalid;
  endsequence
  property p_iso_rw;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_iso_write ##0 s_iso_read |->
        o_mem_rdata == ($past(i_mem_wdata, 2) & DBTC_MSK_ISO);
  endproperty
  a_iso_rw: assert property (p_iso_rw) else $error("iso control readback wrong");
  property p_lower_half;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_mem_rd && !i_mem_addr[DBTC_HALF_BIT]) |=> !o_mem_rvalid;
  endproperty
  a_lower_half: assert property (p_lower_half) else $error("lower half decoded");
  property p_unmapped_zero;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_mem_rd && o_mem_hit && !sel_iso && !sel_async && !sel_link)
      |=> o_mem_rvalid && (o_mem_rdata == '0);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero");
  property p_ee_load;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_ee_wr && i_ee_sel == DBTC_EE_ASYNC)
      |=> async_dma_bus_control_r == ($past(i_ee_word) & DBTC_MSK_ASYNC);
  endproperty
  a_ee_load: assert property (p_ee_load) else $error("eeprom load lost");
  property p_notify_whole;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_at_pkt_whole |=> o_async_tx_link_notify;
  endproperty
  a_notify_whole: assert property (p_notify_whole) else $error("whole packet not notified");
  property p_notify_level;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      ##1 o_async_tx_link_notify != $past(i_at_pkt_whole
        || (i_at_pkt_quads >= {4'h0, async_dma_bus_control_r[DBTC_F_NOTIFY +: 8]}))
      |-> 1'b0;
  endproperty
  a_notify_level: assert property (p_notify_level) else $error("notify level wrong");
  property p_atx_cap;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_async_tx_unit.req
      |-> o_async_tx_unit.burst <= dbtc_quads($past(burst_n[DBTC_U_ATX]));
  endproperty
  a_atx_cap: assert property (p_atx_cap) else $error("async tx burst too long");
  property p_arx_cap;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_async_rx_unit.req
      |-> o_async_rx_unit.burst <= dbtc_quads($past(burst_n[DBTC_U_ARX]));
  endproperty
  a_arx_cap: assert property (p_arx_cap) else $error("async rx burst too long");
endmodule // dbtc_top

//--- verif/dbtc_host_model.sv
// partner model: host buffer and memory serving one transmit dma unit
`timescale 1ns/10ps
module dbtc_host_model
(
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_load,
  input  wire logic                          i_slow,
  input  wire logic [dbtc_pkg::DBTC_QW-1:0]  i_level,
  input  wire logic [dbtc_pkg::DBTC_QW-1:0]  i_remain,
  input  wire dbtc_pkg::dbtc_unit_out_t      i_res,
  output dbtc_pkg::dbtc_unit_in_t            o_drv,
  output logic [7:0]                         o_count,
  output logic [dbtc_pkg::DBTC_QW-1:0]       o_taken
);
  import dbtc_pkg::*;
  logic [3:0] wait_r;
  // ****************************************
  // grant after a short or long delay, then move the burst
  // ****************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_drv   <= '0;
      wait_r  <= 4'h0;
      o_count <= 8'h00;
      o_taken <= '0;
    end
    else if (i_load)
    begin
      o_drv   <= '{1'b1, i_level, i_remain};
      wait_r  <= 4'h2;
      o_count <= 8'h00;
      o_taken <= '0;
    end
    else if (wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
    else if (i_res.req)
    begin
      o_drv.level  <= o_drv.level - i_res.burst;
      o_drv.remain <= o_drv.remain - i_res.burst;
      o_count      <= o_count + 8'h01;
      o_taken      <= o_taken + i_res.burst;
      wait_r       <= i_slow ? 4'h6 : 4'h2;
    end
  end
endmodule // dbtc_host_model

//--- verif/tb_dbtc_top.sv
// testbench for the dma burst and threshold control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_dbtc_top;
  import dbtc_pkg::*;
  logic           clk_sys, rst_n, mem_wr, mem_rd, ee_wr, mdl_load, mdl_slow;
  logic           pkt_whole, hit, rvalid, notify;
  logic [11:0]    mem_addr, cache_q, pkt_q, mdl_level, mdl_remain, m_taken;
  logic [3:0]     mem_be;
  logic [1:0]     ee_sel;
  logic [31:0]    wdata, ee_word, rdata, iso_v, asy_v;
  logic [2:0]     posted, cyc;
  logic [7:0]     m_count;
  dbtc_unit_in_t  ui [3];
  dbtc_unit_in_t  itx_in;
  dbtc_unit_out_t uo [3];
  dbtc_unit_out_t itx_out;
  int             errors, n_checks;
  dbtc_top u_dbtc_top (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_mem_addr(mem_addr),
    .i_mem_wr(mem_wr), .i_mem_rd(mem_rd), .i_mem_be(mem_be), .i_mem_wdata(wdata),
    .o_mem_hit(hit), .o_mem_rdata(rdata), .o_mem_rvalid(rvalid), .i_ee_wr(ee_wr),
    .i_ee_sel(ee_sel), .i_ee_word(ee_word), .i_cache_quads(cache_q),
    .i_isoch_tx_unit(itx_in), .i_isoch_rx_unit(ui[0]), .i_async_tx_unit(ui[1]),
    .i_async_rx_unit(ui[2]), .o_isoch_tx_unit(itx_out), .o_isoch_rx_unit(uo[0]),
    .o_async_tx_unit(uo[1]), .o_async_rx_unit(uo[2]), .i_at_pkt_quads(pkt_q),
    .i_at_pkt_whole(pkt_whole), .o_async_tx_link_notify(notify),
    .o_link_posted_writes(posted), .o_link_cycle_sel(cyc));
  dbtc_host_model u_dbtc_host_model (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_load(mdl_load),
    .i_slow(mdl_slow), .i_level(mdl_level), .i_remain(mdl_remain), .i_res(itx_out),
    .o_drv(itx_in), .o_count(m_count), .o_taken(m_taken));
  // ****************************************
  // helpers
  // ****************************************
  task automatic tally_and_finish;
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(logic [11:0] a, logic [3:0] be, logic [31:0] d);
    mem_addr = a;
    mem_be = be;
    wdata = d;
    mem_wr = 1'b1;
    tick(1);
    mem_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(logic [11:0] a, logic exp_hit, output logic [31:0] d);
    int k;
    mem_addr = a;
    mem_rd = 1'b1;
    #1;
    `CHK("hit", exp_hit, hit)
    tick(1);
    mem_rd = 1'b0;
    d = 32'h0000_0000;
    k = 0;
    if (!exp_hit)
      repeat (2)
      begin
        `CHK("rvalid", 1'b0, rvalid)
        tick(1);
      end
    else
    begin
      while (rvalid !== 1'b1)
      begin
        k++;
        if (k > 4)
        begin
          errors++;
          tally_and_finish();
        end
        tick(1);
      end
      d = rdata;
      tick(1);
    end
  endtask
  task automatic rchk(logic [11:0] a, logic [31:0] e);
    logic [31:0] d;
    rd(a, 1'b1, d);
    `CHK("rdata", e, d)
  endtask
  task automatic ee(logic [1:0] s, logic [31:0] w);
    ee_sel = s;
    ee_word = w;
    ee_wr = 1'b1;
    tick(1);
    ee_wr = 1'b0;
    tick(1);
  endtask
  function automatic logic [12:0] exp_unit(logic [3:0] bn, logic [3:0] tn, dbtc_unit_in_t x,
                                           logic [11:0] c);
    logic [11:0] need;
    logic [11:0] b;
    need = 12'(16 * (tn + 1));
    if (x.remain < need)
      need = x.remain;
    b = 12'(16 * (bn + 1));
    if (x.level < b)
      b = x.level;
    if (x.remain < b)
      b = x.remain;
    if (c != 12'h000 && c < b)
      b = c;
    if (x.en && x.remain != 12'h000 && x.level >= need)
      return {1'b1, b};
    return 13'h0000;
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rchk(DBTC_OFS_ISO, 32'h0000_7373);
    rchk(DBTC_OFS_ASYNC, 32'h0010_7373);
    rchk(DBTC_OFS_LINK, 32'h0000_0020);
    `CHK("posted", 3'h4, posted)
    `CHK("cycle", 3'h0, cyc)
    pkt_q = 12'h00f;
    tick(1);
    `CHK("notify", 1'b0, notify)
    pkt_q = 12'h010;
    tick(1);
    `CHK("notify", 1'b1, notify)
  endtask
  task automatic t_regs;
    logic [31:0] d;
    wr(DBTC_OFS_ISO, 4'hf, 32'hffff_ffff);
    wr(DBTC_OFS_ASYNC, 4'hf, 32'hffff_ffff);
    wr(DBTC_OFS_LINK, 4'hf, 32'hffff_ffff);
    rchk(DBTC_OFS_ISO, 32'h0000_ffff);
    rchk(DBTC_OFS_ASYNC, 32'h00ff_ffff);
    rchk(DBTC_OFS_LINK, 32'h0000_003f);
    `CHK("posted", 3'h7, posted)
    `CHK("cycle", 3'h7, cyc)
    wr(DBTC_OFS_ASYNC, 4'h2, 32'h1234_a500);
    rchk(DBTC_OFS_ASYNC, 32'h00ff_a5ff);
    wr(12'h804, 4'hf, 32'hffff_ffff);
    rchk(12'h804, 32'h0000_0000);
    wr(12'h000, 4'hf, 32'hffff_ffff);
    rd(12'h040, 1'b0, d);
  endtask
  task automatic t_eeprom;
    ee(DBTC_EE_ISO, 32'habcd_1021);
    ee(DBTC_EE_ASYNC, 32'hff05_3204);
    ee(DBTC_EE_LINK, 32'hffff_ff19);
    ee(2'h3, 32'h0000_0000);
    rchk(DBTC_OFS_ISO, 32'h0000_1021);
    rchk(DBTC_OFS_ASYNC, 32'h0005_3204);
    rchk(DBTC_OFS_LINK, 32'h0000_0019);
    `CHK("posted", 3'h3, posted)
    `CHK("cycle", 3'h1, cyc)
    mem_addr = DBTC_OFS_LINK;
    mem_be = 4'hf;
    wdata = 32'h0000_003f;
    mem_wr = 1'b1;
    ee_sel = DBTC_EE_LINK;
    ee_word = 32'h0000_0020;
    ee_wr = 1'b1;
    tick(1);
    mem_wr = 1'b0;
    ee_wr = 1'b0;
    tick(1);
    rchk(DBTC_OFS_LINK, 32'h0000_0020);
    iso_v = 32'h0000_1021;
    asy_v = 32'h0005_3204;
  endtask
  task automatic t_units;
    int          tu [12] = '{0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2};
    logic [11:0] tl [12] = '{31, 32, 100, 100, 100, 47, 100, 100, 79, 80, 50, 80};
    logic [11:0] tr [12] = '{100, 100, 100, 20, 0, 100, 100, 100, 200, 200, 10, 200};
    logic [11:0] tc [12] = '{0, 0, 0, 0, 0, 0, 0, 8, 0, 0, 0, 0};
    logic        te [12] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0};
    logic [3:0]  bn;
    logic [3:0]  tn;
    for (int i = 0; i < 12; i++)
    begin
      ui[tu[i]] = '{te[i], tl[i], tr[i]};
      cache_q = tc[i];
      bn = (tu[i] == 0) ? iso_v[7:4] : (tu[i] == 1) ? asy_v[15:12] : asy_v[7:4];
      tn = (tu[i] == 0) ? iso_v[3:0] : (tu[i] == 1) ? asy_v[11:8] : asy_v[3:0];
      tick(1);
      `CHK("unit", exp_unit(bn, tn, ui[tu[i]], cache_q), {uo[tu[i]].req, uo[tu[i]].burst})
    end
    cache_q = 12'h000;
  endtask
  task automatic t_notify;
    logic [11:0] nq [4] = '{4, 5, 1, 0};
    logic        nw [4] = '{0, 0, 1, 0};
    logic        ne [4] = '{0, 1, 1, 0};
    for (int i = 0; i < 4; i++)
    begin
      pkt_q = nq[i];
      pkt_whole = nw[i];
      tick(1);
      `CHK("notify", ne[i], notify)
    end
  endtask
  task automatic t_model;
    logic [11:0] mr [3] = '{300, 300, 40};
    logic [7:0]  ec [3] = '{2, 2, 1};
    logic [11:0] et [3] = '{200, 200, 40};
    int          k;
    mem_addr = DBTC_OFS_ISO;
    mem_be = 4'hf;
    wdata = 32'h0000_7373;
    mem_wr = 1'b1;
    tick(1);
    mem_wr = 1'b0;
    rchk(DBTC_OFS_ISO, 32'h0000_7373);
    for (int i = 0; i < 3; i++)
    begin
      mdl_level = 12'd200;
      mdl_remain = mr[i];
      mdl_slow = (i == 1);
      mdl_load = 1'b1;
      tick(1);
      mdl_load = 1'b0;
      k = 0;
      while (m_count !== ec[i])
      begin
        k++;
        if (k > 60)
        begin
          errors++;
          tally_and_finish();
        end
        tick(1);
      end
      tick(4);
      `CHK("bursts", ec[i], m_count)
      `CHK("moved", et[i], m_taken)
      `CHK("idle", 1'b0, itx_out.req)
    end
  endtask
  // ****************************************
  // clock and main sequence
  // ****************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    {rst_n, mem_wr, mem_rd, ee_wr, mdl_load, mdl_slow, pkt_whole} = '0;
    {mem_addr, cache_q, pkt_q, mdl_level, mdl_remain, mem_be, ee_sel} = '0;
    {wdata, ee_word, iso_v, asy_v} = '0;
    ui = '{default: '0};
    errors = 0;
    n_checks = 0;
    tick(5);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_eeprom();
    t_units();
    t_notify();
    t_model();
    tally_and_finish();
  end
endmodule // tb_dbtc_top
